/* design/vtpg_pkg.sv */
// Package of the video test pattern generator: raster geometry, video codes,
// pattern selection codes and the sample carrier.
// Assumes a 1920 x 1080 active raster of 10-bit samples.
package vtpg_pkg;

    // ----------------------------------------------------------------
    // Raster geometry
    // ----------------------------------------------------------------
    localparam logic [10:0] ACT_W = 11'h780;
    localparam logic [10:0] ACT_H = 11'h438;
    localparam logic [10:0] HALF_W = 11'h3C0;
    localparam logic [10:0] HALF_H = 11'h21C;

    // ----------------------------------------------------------------
    // Video codes
    // ----------------------------------------------------------------
    localparam logic [9:0] BLACK = 10'h040;
    localparam logic [9:0] WHITE = 10'h3AC;
    localparam logic [9:0] CHROMA_ZERO = 10'h200;
    localparam logic [9:0] MIN_CODE = 10'h004;
    localparam logic [9:0] MAX_CODE = 10'h3FB;
    localparam logic [9:0] MID_GRAY = 10'h1F6;
    localparam logic [9:0] PLUGE_STEP = 10'h012;
    localparam logic [9:0] LUMA_110MV = 10'h0CA;
    localparam logic [9:0] LUMA_200MV = 10'h13A;
    localparam logic [9:0] LUMA_450MV = 10'h273;
    localparam logic [9:0] LUMA_700MV = 10'h3AC;
    localparam logic [9:0] EQ_WORD_A = 10'h300;
    localparam logic [9:0] EQ_WORD_B = 10'h198;
    localparam logic [9:0] EQ_POLARITY = 10'h190;
    localparam logic [9:0] PLL_WORD_A = 10'h200;
    localparam logic [9:0] PLL_WORD_B = 10'h110;
    localparam logic [9:0] COSITE_AMP0 = 10'h3AC;
    localparam logic [9:0] COSITE_AMP1 = 10'h300;
    localparam logic [9:0] COSITE_AMP2 = 10'h100;

    // ----------------------------------------------------------------
    // Pattern layout
    // ----------------------------------------------------------------
    localparam int STEP_COUNT = 10;
    localparam int STEP_WHITE_DEN = 10;
    localparam int STEP_GRAY_DEN = 31;
    localparam logic [10:0] STEP_X0 = 11'h0A0;
    localparam logic [10:0] STEP_W = 11'h0A0;
    localparam logic [10:0] STEP_Y0 = 11'h1B8;
    localparam logic [10:0] STEP_Y1 = 11'h27F;
    localparam logic [10:0] PLUGE_X0 = 11'h064;
    localparam logic [10:0] PLUGE_BAR_W = 11'h064;
    localparam logic [10:0] PLUGE_Y0 = 11'h12C;
    localparam logic [10:0] PLUGE_Y1 = 11'h30B;
    localparam logic [10:0] BOX_X0 = 11'h5DC;
    localparam logic [10:0] BOX_X1 = 11'h707;
    localparam logic [10:0] BOX_Y0 = 11'h0B4;
    localparam logic [10:0] BOX_H = 11'h0B4;
    localparam logic [10:0] CHK_W = 11'h1E0;
    localparam logic [10:0] CHK_H = 11'h10E;
    localparam logic [10:0] WIN_X0 = 11'h294;
    localparam logic [10:0] WIN_X1 = 11'h4EB;
    localparam logic [10:0] WIN_Y0 = 11'h0F0;
    localparam logic [10:0] WIN_Y1 = 11'h347;
    localparam int CA_MARKS = 4;
    localparam int CA_STEP_X = 48;
    localparam int CA_STEP_Y = 27;
    localparam int NARROW_X0 = 240;
    localparam int NARROW_STEP_X = 36;
    localparam logic [6:0] GRID = 7'h78;
    localparam logic [6:0] GRID_MID = 7'h3C;
    localparam logic [10:0] PB_POS_X = 11'h1E0;
    localparam logic [10:0] PB_BAR_X0 = 11'h3C0;
    localparam logic [10:0] PB_BAR_X1 = 11'h59F;
    localparam logic [10:0] PB_NEG_X = 11'h4B0;
    localparam int COLOR_COUNT = 8;
    localparam int COLOR_X0 = 120;
    localparam int COLOR_STEP = 240;

    // ----------------------------------------------------------------
    // Selection codes and carrier
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        PAT_STEP_WHITE = 4'h0,
        PAT_STEP_GRAY = 4'h1,
        PAT_PLUGE = 4'h2,
        PAT_CHECKER = 4'h3,
        PAT_WINDOW = 4'h4,
        PAT_PROD_APERTURE = 4'h5,
        PAT_CLEAN_APERTURE = 4'h6,
        PAT_CONVERGENCE = 4'h7,
        PAT_PULSE_BAR = 4'h8,
        PAT_COLOR_PULSE = 4'h9,
        PAT_COSITE = 4'hA,
        PAT_EQUALIZER = 4'hB,
        PAT_PLL = 4'hC,
        PAT_MATRIX = 4'hD,
        PAT_CONVERTER = 4'hE
    } vtpg_pattern_t;

    typedef enum logic [0:0] {
        MODE_GENERATE = 1'b0,
        MODE_CONVERT = 1'b1
    } vtpg_mode_t;

    typedef struct packed {
        logic [9:0] luma;
        logic [9:0] chromaB;
        logic [9:0] chromaR;
        logic frameStart;
        logic lineEnd;
    } vtpg_sample_t;

endpackage : vtpg_pkg

/* design/vtpg_skid_buffer.sv */
// Two-entry buffer between the pattern engine and the serial link.
// Assumes one clock; input ready goes low once a stall on the output side has filled the spare entry.
`timescale 1ns/100ps
`default_nettype none
module vtpg_skid_buffer
    import vtpg_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire vtpg_sample_t inData,
    output logic outValid,
    input wire logic outReady,
    output vtpg_sample_t outData
);
    logic spareValid;
    logic next_spareValid;
    logic next_outValid;
    vtpg_sample_t spare;
    vtpg_sample_t next_spare;
    vtpg_sample_t next_outData;
    logic push;

    assign inReady = ~spareValid;
    assign push = inValid & ~spareValid;

    // ----------------------------------------------------------------
    // Entry steering
    // ----------------------------------------------------------------
    always_comb begin
        next_spareValid = spareValid;
        next_spare = spare;
        next_outValid = outValid;
        next_outData = outData;
        if (!outValid || outReady) begin
            if (spareValid) begin
                next_outData = spare;
                next_outValid = 1'b1;
                next_spareValid = 1'b0;
            end else begin
                next_outData = inData;
                next_outValid = push;
            end
        end else if (push) begin
            next_spare = inData;
            next_spareValid = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            spareValid <= 1'b0;
            spare <= '0;
            outValid <= 1'b0;
            outData <= '0;
        end else begin
            spareValid <= next_spareValid;
            spare <= next_spare;
            outValid <= next_outValid;
            outData <= next_outData;
        end
    end

endmodule : vtpg_skid_buffer
`default_nettype wire

/* design/vtpg_top.sv */
// Video test pattern generator: full-raster 10-bit sample stream.
// Assumes the link side pulls samples with ready/valid and that format
// flags are steady within a frame.
//
// Behaviour
// - Ten white-scale patches, 1/10 to full
// - Ten dark-gray patches, 1/31 to 10/31
// - Four gray boxes right: 110/200/450/700 mV
// - Three black bars left; below-black clipped for XYZ
// - Checkerboard is four by four, black/white
// - White square centred on black
// - Edge lines one sample, unfiltered
// - Clean aperture and 2.5% overscan markers
// - Widescreen adds central 4:3 marker set
// - Grid lines two lines or two samples
// - Square grid, centre dots, single width
// - Positive pulse on minimum, negative on maximum
// - Eight colour pulses, black top, white bottom
// - Single centre sample, distinct channel amplitudes
// - Equalizer alternates 300h and 198h
// - 4:2:2 luma carries 198h, chroma 300h
// - Every second frame first sample 190h
// - PLL pattern alternates 200h and 110h
// - Matrix: equalizer top, PLL bottom
// - Converter only with 3G; patterns return
`timescale 1ns/100ps
`default_nettype none
module vtpg_top
    import vtpg_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic selStrobe,
    input wire vtpg_pattern_t selPattern,
    input wire logic fmt3g,
    input wire logic fmt422,
    input wire logic fmtRgb,
    input wire logic fmtXyz,
    input wire logic fmtWide,
    input wire logic outReady,
    output logic outValid,
    output vtpg_sample_t outSample,
    output vtpg_pattern_t activePattern,
    output vtpg_mode_t opMode
);
    logic [10:0] xPos;
    logic [10:0] yPos;
    logic [10:0] next_xPos;
    logic [10:0] next_yPos;
    logic [6:0] gridX;
    logic [6:0] gridY;
    logic [6:0] next_gridX;
    logic [6:0] next_gridY;
    logic frameOdd;
    logic next_frameOdd;
    logic pendValid;
    logic next_pendValid;
    vtpg_pattern_t pendPattern;
    vtpg_pattern_t next_pendPattern;
    vtpg_pattern_t next_activePattern;
    vtpg_mode_t next_opMode;
    logic genValid;
    logic bufReady;
    logic push;
    logic lineLast;
    logic frameLast;
    logic frameFirst;
    vtpg_sample_t sample;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] stepLevel(input int k, input int den);
        int span;
        span = int'(WHITE) - int'(BLACK);
        return 10'(int'(BLACK) + (span * k) / den);
    endfunction : stepLevel

    function automatic int bandIdx(input logic [10:0] p, input logic [10:0] org,
                                   input logic [10:0] w, input int n);
        int idx;
        idx = -1;
        for (int i = 0; i < n; i++) begin
            if (int'(p) >= int'(org) + i * int'(w) &&
                int'(p) < int'(org) + (i + 1) * int'(w)) begin
                idx = i;
            end
        end
        return idx;
    endfunction : bandIdx

    function automatic int pulseTap(input int p, input int c);
        int tap;
        tap = 0;
        if (p == c) begin
            tap = 2;
        end else if (p == c - 1 || p == c + 1) begin
            tap = 1;
        end
        return tap;
    endfunction : pulseTap

    function automatic logic onPair(input int p, input int m);
        return (p == m - 1) || (p == m);
    endfunction : onPair

    function automatic logic [9:0] addTap(input logic [9:0] base, input int tap,
                                          input int span, input logic neg);
        int amt;
        amt = (tap * span) / 2;
        return neg ? 10'(int'(base) - amt) : 10'(int'(base) + amt);
    endfunction : addTap

    // ----------------------------------------------------------------
    // Selection and raster counters
    // ----------------------------------------------------------------
    assign genValid = (opMode == MODE_GENERATE) && !(pendValid && frameFirst);
    assign push = genValid & bufReady;
    assign lineLast = (xPos == ACT_W - 11'h001);
    assign frameLast = lineLast && (yPos == ACT_H - 11'h001);
    assign frameFirst = (xPos == 11'h000) && (yPos == 11'h000);

    always_comb begin
        next_pendValid = pendValid;
        next_pendPattern = pendPattern;
        next_activePattern = activePattern;
        next_opMode = opMode;
        next_xPos = xPos;
        next_yPos = yPos;
        next_gridX = gridX;
        next_gridY = gridY;
        next_frameOdd = frameOdd;
        if (selStrobe) begin
            if (selPattern == PAT_CONVERTER) begin
                if (fmt3g) begin
                    next_opMode = MODE_CONVERT;
                end
            end else begin
                next_opMode = MODE_GENERATE;
                next_pendPattern = selPattern;
                next_pendValid = 1'b1;
            end
        end
        if (opMode == MODE_CONVERT && !fmt3g) begin
            next_opMode = MODE_GENERATE;
        end
        // New pattern takes effect only on a frame boundary
        if (pendValid && (!genValid || (push && frameLast) || (frameFirst && !push))) begin
            next_activePattern = pendPattern;
            next_pendValid = selStrobe && (selPattern != PAT_CONVERTER);
        end
        if (!genValid) begin
            next_xPos = 11'h000;
            next_yPos = 11'h000;
            next_gridX = 7'h00;
            next_gridY = 7'h00;
        end else if (push) begin
            next_xPos = xPos + 11'h001;
            next_gridX = (gridX == GRID - 7'h01) ? 7'h00 : gridX + 7'h01;
            if (lineLast) begin
                next_xPos = 11'h000;
                next_gridX = 7'h00;
                next_yPos = yPos + 11'h001;
                next_gridY = (gridY == GRID - 7'h01) ? 7'h00 : gridY + 7'h01;
                if (frameLast) begin
                    // Wrap to the next frame; a pending pattern takes over with it
                    next_yPos = 11'h000;
                    next_gridY = 7'h00;
                    next_frameOdd = ~frameOdd;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pendValid <= 1'b0;
            pendPattern <= PAT_STEP_WHITE;
            activePattern <= PAT_STEP_WHITE;
            opMode <= MODE_GENERATE;
            xPos <= 11'h000;
            yPos <= 11'h000;
            gridX <= 7'h00;
            gridY <= 7'h00;
            frameOdd <= 1'b0;
        end else begin
            pendValid <= next_pendValid;
            pendPattern <= next_pendPattern;
            activePattern <= next_activePattern;
            opMode <= next_opMode;
            xPos <= next_xPos;
            yPos <= next_yPos;
            gridX <= next_gridX;
            gridY <= next_gridY;
            frameOdd <= next_frameOdd;
        end
    end

    // ----------------------------------------------------------------
    // Sample synthesis
    // ----------------------------------------------------------------
    always_comb begin
        logic [9:0] lvl;
        logic [9:0] wordA;
        logic [9:0] wordB;
        logic line;
        int px;
        int py;
        int idx;
        int tap;
        int span;
        lvl = BLACK;
        wordA = EQ_WORD_A;
        wordB = EQ_WORD_B;
        line = 1'b0;
        px = int'(xPos);
        py = int'(yPos);
        idx = -1;
        tap = 0;
        span = int'(MAX_CODE) - int'(MIN_CODE);
        sample.frameStart = frameFirst;
        sample.lineEnd = lineLast;
        sample.luma = BLACK;
        sample.chromaB = fmtRgb ? BLACK : CHROMA_ZERO;
        sample.chromaR = fmtRgb ? BLACK : CHROMA_ZERO;
        case (activePattern)
            PAT_STEP_WHITE, PAT_STEP_GRAY: begin
                lvl = MID_GRAY;
                idx = bandIdx(xPos, STEP_X0, STEP_W, STEP_COUNT);
                if (idx >= 0 && yPos >= STEP_Y0 && yPos <= STEP_Y1) begin
                    if (activePattern == PAT_STEP_WHITE) begin
                        lvl = stepLevel(idx + 1, STEP_WHITE_DEN);
                    end else begin
                        lvl = stepLevel(idx + 1, STEP_GRAY_DEN);
                    end
                end
            end
            PAT_PLUGE: begin
                idx = bandIdx(yPos, BOX_Y0, BOX_H, 4);
                if (xPos >= BOX_X0 && xPos <= BOX_X1 && idx >= 0) begin
                    case (idx)
                        0: lvl = LUMA_110MV;
                        1: lvl = LUMA_200MV;
                        2: lvl = LUMA_450MV;
                        default: lvl = LUMA_700MV;
                    endcase
                end
                idx = bandIdx(xPos, PLUGE_X0, PLUGE_BAR_W, 3);
                if (yPos >= PLUGE_Y0 && yPos <= PLUGE_Y1) begin
                    if (idx == 0 && !fmtXyz) begin
                        lvl = BLACK - PLUGE_STEP;
                    end else if (idx == 2) begin
                        lvl = BLACK + PLUGE_STEP;
                    end
                end
            end
            PAT_CHECKER: begin
                if ((bandIdx(xPos, 11'h000, CHK_W, 4) + bandIdx(yPos, 11'h000, CHK_H, 4)) % 2
                    == 1) begin
                    lvl = WHITE;
                end
            end
            PAT_WINDOW: begin
                if (xPos >= WIN_X0 && xPos <= WIN_X1 && yPos >= WIN_Y0 && yPos <= WIN_Y1) begin
                    lvl = WHITE;
                end
            end
            PAT_PROD_APERTURE: begin
                if (xPos == 11'h000 || lineLast || yPos == 11'h000 ||
                    yPos == ACT_H - 11'h001) begin
                    lvl = WHITE;
                end
            end
            PAT_CLEAN_APERTURE: begin
                for (int k = 1; k <= CA_MARKS; k++) begin
                    line |= onPair(px, k * CA_STEP_X);
                    line |= onPair(px, int'(ACT_W) - k * CA_STEP_X);
                    line |= onPair(py, k * CA_STEP_Y);
                    line |= onPair(py, int'(ACT_H) - k * CA_STEP_Y);
                end
                if (fmtWide) begin
                    for (int k = 0; k <= CA_MARKS; k++) begin
                        line |= onPair(px, NARROW_X0 + k * NARROW_STEP_X);
                        line |= onPair(px, int'(ACT_W) - NARROW_X0 - k * NARROW_STEP_X);
                    end
                end
                lvl = line ? WHITE : BLACK;
            end
            PAT_CONVERGENCE: begin
                if (gridX == 7'h00 || gridY == 7'h00 || lineLast || yPos == ACT_H - 11'h001 ||
                    (gridX == GRID_MID && gridY == GRID_MID)) begin
                    lvl = WHITE;
                end
            end
            PAT_PULSE_BAR: begin
                lvl = MIN_CODE;
                tap = pulseTap(px, int'(PB_POS_X));
                lvl = addTap(MIN_CODE, tap, span, 1'b0);
                if (xPos >= PB_BAR_X0 && xPos <= PB_BAR_X1) begin
                    tap = pulseTap(px, int'(PB_NEG_X));
                    lvl = addTap(MAX_CODE, tap, span, 1'b1);
                end
            end
            PAT_COLOR_PULSE: begin
                span = int'(WHITE) - int'(BLACK);
                sample.luma = (yPos < HALF_H) ? BLACK : WHITE;
                sample.chromaB = sample.luma;
                sample.chromaR = sample.luma;
                for (int k = 0; k < COLOR_COUNT; k++) begin
                    tap = pulseTap(px, COLOR_X0 + k * COLOR_STEP);
                    if (tap != 0 && yPos < HALF_H) begin
                        sample.chromaR = addTap(BLACK, tap * (k / 4 % 2), span, 1'b0);
                        sample.luma = addTap(BLACK, tap * (k / 2 % 2), span, 1'b0);
                        sample.chromaB = addTap(BLACK, tap * (k % 2), span, 1'b0);
                    end else if (tap != 0) begin
                        sample.chromaR = addTap(WHITE, tap * (1 - k / 4), span, 1'b1);
                        sample.luma = addTap(WHITE, tap * (1 - k / 2 % 2), span, 1'b1);
                        sample.chromaB = addTap(WHITE, tap * (1 - k % 2), span, 1'b1);
                    end
                end
            end
            PAT_COSITE: begin
                if (xPos == HALF_W && yPos == HALF_H) begin
                    sample.luma = COSITE_AMP0;
                    sample.chromaB = COSITE_AMP1;
                    sample.chromaR = COSITE_AMP2;
                end
            end
            PAT_EQUALIZER, PAT_PLL, PAT_MATRIX: begin
                if (activePattern == PAT_PLL ||
                    (activePattern == PAT_MATRIX && yPos >= HALF_H)) begin
                    wordA = PLL_WORD_A;
                    wordB = PLL_WORD_B;
                end else if (frameOdd && frameFirst) begin
                    wordB = EQ_POLARITY;
                end
                if (fmt422) begin
                    sample.luma = wordB;
                    sample.chromaB = wordA;
                    sample.chromaR = wordA;
                end else begin
                    sample.luma = xPos[0] ? wordA : wordB;
                    sample.chromaB = sample.luma;
                    sample.chromaR = sample.luma;
                end
            end
            default: begin
                lvl = BLACK;
            end
        endcase
        if (activePattern <= PAT_PULSE_BAR) begin
            sample.luma = lvl;
            if (fmtRgb) begin
                sample.chromaB = lvl;
                sample.chromaR = lvl;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output buffer
    // ----------------------------------------------------------------
    vtpg_skid_buffer u_buffer (
        .mclk(mclk),
        .reset(reset),
        .inValid(genValid),
        .inReady(bufReady),
        .inData(sample),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outSample)
    );

endmodule : vtpg_top
`default_nettype wire

/* tb/vtpg_sink.sv */
// Sink model of the serial link: takes samples, stalls three of four cycles.
// Assumes the bench changes the stall mode only between frames.
`timescale 1ns/100ps
`default_nettype none
module vtpg_sink
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic stall,
    output logic outReady
);
    logic [1:0] phase;
    always_ff @(posedge mclk) begin
        phase <= reset ? 2'h0 : phase + 2'h1;
    end
    assign outReady = !stall || phase == 2'h3;
endmodule : vtpg_sink
`default_nettype wire

/* tb/vtpg_chk.sv */
// Assertions on the generator's ports.
// Assumes binding to vtpg_top.
`timescale 1ns/100ps
`default_nettype none
module vtpg_chk
    import vtpg_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic selStrobe,
    input wire vtpg_pattern_t selPattern,
    input wire logic fmt3g,
    input wire logic fmt422,
    input wire logic outReady,
    input wire logic outValid,
    input wire vtpg_sample_t outSample,
    input wire vtpg_pattern_t activePattern,
    input wire vtpg_mode_t opMode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic cv;
    logic eq;
    logic pl;
    assign cv = selStrobe && selPattern == PAT_CONVERTER;
    assign eq = outValid && outReady && activePattern == PAT_EQUALIZER && !fmt422;
    assign pl = outValid && outReady && activePattern == PAT_PLL && !fmt422;
    reset_quiet_a: assert property (disable iff (1'b0) reset |=> !outValid &&
        opMode == MODE_GENERATE && activePattern == PAT_STEP_WHITE) else $error("reset state");
    conv_refuse_a: assert property (cv && !fmt3g && opMode == MODE_GENERATE
        |=> opMode == MODE_GENERATE) else $error("converter without 3G");
    conv_enter_a: assert property (cv && fmt3g |=> opMode == MODE_CONVERT)
        else $error("converter not entered");
    conv_leave_a: assert property (opMode == MODE_CONVERT && selStrobe && !cv
        |=> opMode == MODE_GENERATE) else $error("converter not left");
    stall_hold_a: assert property (outValid && !outReady
        |=> outValid && $stable(outSample)) else $error("sample lost in stall");
    eq_pair_a: assert property (eq && outSample.luma == EQ_WORD_B
        |=> !outValid || outSample.luma == EQ_WORD_A) else $error("equalizer pair");
    pll_pair_a: assert property (pl && outSample.luma == PLL_WORD_B
        |=> !outValid || outSample.luma == PLL_WORD_A) else $error("pll pair");
    eq_chroma_a: assert property (outValid && activePattern == PAT_EQUALIZER && fmt422 &&
        outSample.luma == EQ_WORD_B |-> outSample.chromaB == EQ_WORD_A &&
        outSample.chromaR == EQ_WORD_A) else $error("equalizer chroma");
endmodule : vtpg_chk
bind vtpg_top vtpg_chk u_chk (.*);
`default_nettype wire

/* tb/test_video_test_pattern_generator.sv */
// Self-checking bench of the test pattern generator.
// Assumes the sink model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module test_video_test_pattern_generator
    import vtpg_pkg::*;
;
    typedef struct packed {
        vtpg_pattern_t pat;
        logic f422;
        logic [11:0] n;
        logic [9:0] v;
    } vtpg_row_t;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic selStrobe = 1'b0;
    vtpg_pattern_t selPattern = PAT_STEP_WHITE;
    logic fmt3g = 1'b0;
    logic fmt422 = 1'b0;
    logic stall = 1'b0;
    logic outReady;
    logic outValid;
    vtpg_sample_t outSample;
    vtpg_pattern_t activePattern;
    vtpg_mode_t opMode;
    int miscompares = 0;
    int checked = 0;
    vtpg_row_t rows [16] = '{
        '{PAT_STEP_WHITE, 1'b0, 12'h000, MID_GRAY},
        '{PAT_WINDOW, 1'b0, 12'h000, BLACK},
        '{PAT_PROD_APERTURE, 1'b0, 12'h005, WHITE},
        '{PAT_PROD_APERTURE, 1'b0, 12'h780, WHITE},
        '{PAT_PROD_APERTURE, 1'b0, 12'h781, BLACK},
        '{PAT_COLOR_PULSE, 1'b0, 12'h000, BLACK},
        '{PAT_COLOR_PULSE, 1'b0, 12'h708, WHITE},
        '{PAT_EQUALIZER, 1'b0, 12'h000, EQ_WORD_B},
        '{PAT_EQUALIZER, 1'b0, 12'h001, EQ_WORD_A},
        '{PAT_PLL, 1'b0, 12'h000, PLL_WORD_B},
        '{PAT_PLL, 1'b0, 12'h007, PLL_WORD_A},
        '{PAT_MATRIX, 1'b0, 12'h002, EQ_WORD_B},
        '{PAT_EQUALIZER, 1'b1, 12'h002, EQ_WORD_B},
        '{PAT_CHECKER, 1'b0, 12'h1E0, WHITE},
        '{PAT_PULSE_BAR, 1'b0, 12'h1E0, MAX_CODE},
        '{PAT_CLEAN_APERTURE, 1'b0, 12'h02F, WHITE}
    };
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    vtpg_top u_dut (.mclk(mclk), .reset(reset), .selStrobe(selStrobe),
        .selPattern(selPattern), .fmt3g(fmt3g), .fmt422(fmt422), .fmtRgb(1'b0),
        .fmtXyz(1'b0), .fmtWide(1'b0), .outReady(outReady), .outValid(outValid),
        .outSample(outSample), .activePattern(activePattern), .opMode(opMode));
    vtpg_sink u_sink (.mclk(mclk), .reset(reset), .stall(stall), .outReady(outReady));
    task check(input string name, input logic [9:0] exp, input logic [9:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task pick(input vtpg_pattern_t p);
        selPattern = p;
        selStrobe = 1'b1;
        @(negedge mclk);
        selStrobe = 1'b0;
        @(negedge mclk);
    endtask : pick
    task test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        int n;
        int w;
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        fmt3g = 1'b1;
        foreach (rows[i]) begin
            stall = (i % 2) == 1;
            pick(PAT_CONVERTER);
            repeat (8) @(negedge mclk);
            fmt422 = rows[i].f422;
            pick(rows[i].pat);
            check("pattern", 10'(rows[i].pat), 10'(activePattern));
            n = -1;
            w = 0;
            while (w < 20000) begin
                if (outValid === 1'b1 && outReady === 1'b1) begin
                    if (n >= 0 || outSample.frameStart === 1'b1) n++;
                    if (n == int'(rows[i].n)) break;
                end
                @(negedge mclk);
                w++;
            end
            check("wait", 10'h000, 10'(w >= 20000));
            check("luma", rows[i].v, outSample.luma);
        end
        fmt3g = 1'b0;
        pick(PAT_CONVERTER);
        check("refuse", 10'(MODE_GENERATE), 10'(opMode));
        fmt3g = 1'b1;
        pick(PAT_CONVERTER);
        check("convert", 10'(MODE_CONVERT), 10'(opMode));
        pick(PAT_PLL);
        check("return", 10'(MODE_GENERATE), 10'(opMode));
        repeat (3000) @(negedge mclk);
        check("persist", 10'(PAT_PLL), 10'(activePattern));
        pick(PAT_CONVERTER);
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        check("rstValid", 10'h000, 10'(outValid));
        check("rstPattern", 10'(PAT_STEP_WHITE), 10'(activePattern));
        check("rstMode", 10'(MODE_GENERATE), 10'(opMode));
        check("rstSample", 10'h000, outSample.luma);
        reset = 1'b0;
        @(negedge mclk);
        check("rstFirst", 10'h003, 10'({outValid, outSample.frameStart}));
        test_done();
    end
    initial begin
        repeat (90000) @(posedge mclk);
        miscompares++;
        test_done();
    end
endmodule : test_video_test_pattern_generator
`default_nettype wire
